// File: dv/scfg_i2c_host.sv
`timescale 1ns/10ps
module scfg_i2c_host (
    // Clock.
    input  wire logic clk_sys,
    // Line levels as seen on the wires.
    input  wire logic sclLine,
    input  wire logic sdaLine,
    // Controller drivers; 1 means released to the pull-up.
    output logic      sclDrv,
    output logic      sdaDrv
);
    ////////////////////////////////////////
    // Both lines start released, so the bus idles high.
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end

    // All line changes land on falling edges, away from the sampling edge.
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // wait for clock.
    // Release the clock and wait, bounded, until no one holds it low.
    task automatic sclHigh();
        int k;
        k = 0;
        sclDrv = 1'b1;
        while (sclLine !== 1'b1 && k < 64) begin
            tick(1);
            k++;
        end
        tick(2);
    endtask

    // Data only moves while the clock is low; low phases are long enough
    // for the target to turn its data driver round after each fall.
    task automatic bitIo(input logic b, output logic got);
        sdaDrv = b;
        tick(3);
        sclHigh();
        got = sdaLine;
        tick(2);
        sclDrv = 1'b0;
        tick(3);
    endtask

    // start condition.
    // Data falls while the clock is high; also serves as repeated start.
    task automatic start();
        sdaDrv = 1'b1;
        tick(3);
        sclHigh();
        sdaDrv = 1'b0;
        tick(4);
        sclDrv = 1'b0;
        tick(3);
    endtask

    // stop condition.
    // Data rises while the clock is high, closing every transaction.
    task automatic stop();
        sdaDrv = 1'b0;
        tick(3);
        sclHigh();
        sdaDrv = 1'b1;
        tick(4);
    endtask

    // Byte out, most significant bit first, then the target's answer bit.
    task automatic sendByte(input logic [7:0] v, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bitIo(v[i], g);
        end
        bitIo(1'b1, ack);
    endtask

    // controller acknowledge.
    // Acknowledge to ask for more, not-acknowledge after the last byte.
    task automatic readByte(input logic last, output logic [7:0] v);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, g);
            v[i] = g;
        end
        bitIo(last, g);
    endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/10ps
module tb import scfg_pkg::*;;
    typedef struct {
        logic [1:0] lvl;
        logic [2:0] code;
        logic [6:0] addr;
        logic       ref33;
        logic [2:0] mode;
        logic       clkOe;
    } scfg_row_t;
    logic clk_sys, rst, powerDownReleasePin, sclIn, sdaIn, sclDrv, sdaDrv;
    logic sdaOut, sdaOe, sensorClkOut, sensorClkOe, configDone, ioRef33, modeOverride;
    logic [1:0] addressStrapLevel;
    logic [2:0] modeStrapCode, opMode;
    logic [6:0] targetAddr;
    logic [7:0] q [$];
    int         failures, nTests, cyc;
    scfg_row_t  rows [5] = '{
        '{2'h0, 3'h0, ADDR_LO, 1'b0, MODE_SYNC, 1'b1},
        '{2'h1, 3'h2, ADDR_HI, 1'b0, MODE_NSEXT, 1'b1},
        '{2'h2, 3'h3, ADDR_LO, 1'b1, MODE_NSINT, 1'b0},
        '{2'h3, 3'h5, ADDR_HI, 1'b1, MODE_DVP, 1'b0},
        '{2'h1, 3'h7, ADDR_HI, 1'b0, MODE_SYNC, 1'b1}};

    // The data wire is a wired AND of both parties over a pull-up.
    assign sclIn = sclDrv;
    assign sdaIn = sdaDrv & ~(sdaOe & ~sdaOut);

    scfg_top i_scfg_top (.clk_sys(clk_sys), .rst(rst),
        .powerDownReleasePin(powerDownReleasePin), .addressStrapLevel(addressStrapLevel),
        .modeStrapCode(modeStrapCode), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .sensorClkOut(sensorClkOut), .sensorClkOe(sensorClkOe),
        .configDone(configDone), .targetAddr(targetAddr), .ioRef33(ioRef33),
        .opMode(opMode), .modeOverride(modeOverride));
    scfg_i2c_host i_scfg_i2c_host (.clk_sys(clk_sys), .sclLine(sclIn), .sdaLine(sdaIn),
        .sclDrv(sclDrv), .sdaDrv(sdaDrv));

    ////////////////////////////////////////
    // Clock at 10 MHz and a cycle count read only on falling edges.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Power down, present new strap levels, then release again.
    task automatic relatch(input logic [1:0] lvl, input logic [2:0] code);
        powerDownReleasePin = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(8'(configDone), 8'h00);
        check(8'(sensorClkOe), 8'h00);
        addressStrapLevel = lvl;
        modeStrapCode = code;
        @(negedge clk_sys);
        powerDownReleasePin = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(8'(configDone), 8'h01);
    endtask

    // Register write burst; every byte must be acknowledged.
    task automatic wrRegs(input logic [7:0] ptr, input logic [7:0] d [$]);
        logic a;
        i_scfg_i2c_host.start();
        i_scfg_i2c_host.sendByte({ADDR_LO, 1'b0}, a);
        check(8'(a), 8'h00);
        d.push_front(ptr);
        foreach (d[i]) begin
            i_scfg_i2c_host.sendByte(d[i], a);
            check(8'(a), 8'h00);
        end
        i_scfg_i2c_host.stop();
    endtask

    // Pointer write, repeated start, then a read burst of n bytes.
    task automatic rdRegs(input logic [7:0] ptr, input int n);
        logic       a;
        logic [7:0] v;
        q.delete();
        i_scfg_i2c_host.start();
        i_scfg_i2c_host.sendByte({ADDR_LO, 1'b0}, a);
        i_scfg_i2c_host.sendByte(ptr, a);
        i_scfg_i2c_host.start();
        i_scfg_i2c_host.sendByte({ADDR_LO, 1'b1}, a);
        check(8'(a), 8'h00);
        for (int i = 0; i < n; i++) begin
            i_scfg_i2c_host.readByte(i == n - 1, v);
            q.push_back(v);
        end
        i_scfg_i2c_host.stop();
    endtask

    // Waits, bounded, for the next rising edge of the sensor clock.
    task automatic edgeUp();
        int k;
        k = 0;
        while (sensorClkOut !== 1'b0 && k < 64) begin
            @(negedge clk_sys);
            k++;
        end
        while (sensorClkOut !== 1'b1 && k < 64) begin
            @(negedge clk_sys);
            k++;
        end
    endtask

    ////////////////////////////////////////
    // Watchdog sized well above the few thousand cycles the tests need.
    initial begin
        #(20000 * 100);
        failures++;
        complete_run();
    end

    // Reset, the strap table, then hand-written register cases.
    initial begin
        int         c0;
        logic       a;
        rst = 1'b1;
        powerDownReleasePin = 1'b0;
        addressStrapLevel = 2'h0;
        modeStrapCode = 3'h0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        check(8'(targetAddr), 8'h18);
        check(8'(sensorClkOe), 8'h00);
        foreach (rows[i]) begin
            relatch(rows[i].lvl, rows[i].code);
            check(8'(targetAddr), 8'(rows[i].addr));
            check(8'(ioRef33), 8'(rows[i].ref33));
            check(8'(opMode), 8'(rows[i].mode));
            check(8'(sensorClkOe), 8'(rows[i].clkOe));
            addressStrapLevel = ~rows[i].lvl;
            modeStrapCode = 3'h3;
            repeat (3) @(negedge clk_sys);
            check(8'(targetAddr), 8'(rows[i].addr));
            check(8'(opMode), 8'(rows[i].mode));
        end
        relatch(2'h0, 3'h0);
        // Reset clock parameters read back in one burst, then status and a hole.
        rdRegs(REG_CLKM, 2);
        check(q[0], 8'h41);
        check(q[1], 8'h1b);
        rdRegs(REG_STATUS, 1);
        check(q[0], 8'h01);
        rdRegs(8'h05, 1);
        check(q[0], 8'h00);
        // The other address is left unanswered.
        i_scfg_i2c_host.start();
        i_scfg_i2c_host.sendByte({ADDR_HI, 1'b0}, a);
        check(8'(a), 8'h01);
        check(8'(sdaOut), 8'h00);
        i_scfg_i2c_host.stop();
        // Without the override bit the mode field ignores writes.
        wrRegs(REG_MODE, '{8'h03});
        check(8'(opMode), 8'(MODE_SYNC));
        check(8'(modeOverride), 8'h00);
        wrRegs(REG_MODE, '{8'h13});
        check(8'(opMode), 8'(MODE_NSINT));
        check(8'(sensorClkOe), 8'h00);
        rdRegs(REG_MODE, 1);
        check(q[0], 8'h13);
        // Divider 2, multiplier 1, divisor 3 gives a six-cycle clock.
        wrRegs(REG_CLKM, '{8'h21, 8'h03});
        wrRegs(REG_MODE, '{8'h10});
        edgeUp();
        c0 = cyc;
        edgeUp();
        check(8'(cyc - c0), 8'h06);
        rdRegs(REG_CLKM, 2);
        check(q[0], 8'h21);
        check(q[1], 8'h03);
        // A new release takes the strap mode again and drops the override.
        relatch(2'h0, 3'h2);
        check(8'(opMode), 8'(MODE_NSEXT));
        check(8'(modeOverride), 8'h00);
        // A reset in mid-run clears the straps; with the release pin already
        // high the first edge after it latches the present straps again.
        addressStrapLevel = 2'h1;
        rst = 1'b1;
        @(negedge clk_sys);
        check(8'(targetAddr), 8'(ADDR_LO));
        check(8'(configDone), 8'h00);
        check(8'(sensorClkOe), 8'h00);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(8'(targetAddr), 8'(ADDR_HI));
        check(8'(opMode), 8'(MODE_NSEXT));
        check(8'(configDone), 8'h01);
        check(8'(sensorClkOe), 8'h01);
        complete_run();
    end
endmodule

// File: rtl/scfg_i2c_target.sv
`timescale 1ns/10ps
module scfg_i2c_target import scfg_pkg::*; (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Configuration.
    input  wire logic       enable,
    input  wire logic [6:0] ownAddr,
    // Bus lines.
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaLow,
    // Register side.
    input  wire logic [7:0] rdData,
    output logic [7:0]      rdAddr,
    output scfg_wr_t        wr
);

    logic        sclQ;
    logic        sdaQ;
    logic        rw;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    scfg_state_t state;

    // Line events, seen on the sampled lines.
    // start stop detect.
    wire startSeen = sclIn && sclQ && sdaQ && !sdaIn;
    wire stopSeen  = sclIn && sclQ && !sdaQ && sdaIn;
    wire sclRise   = sclIn && !sclQ;
    wire sclFall   = !sclIn && sclQ;
    wire byteDone  = bitCnt == 4'h8;
    wire addrHit   = shift[7:1] == ownAddr;

    ////////////////////////////////////////////////////////////////////////
    // Line history.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
        end else begin
            sclQ <= sclIn;
            sdaQ <= sdaIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte engine; data changes only while SCL is low, so it never fakes a
    // START or STOP of its own.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state  <= ST_IDLE;
            bitCnt <= 4'h0;
            shift  <= 8'h00;
            rw     <= 1'b0;
            sdaLow <= 1'b0;
            rdAddr <= 8'h00;
            wr     <= '0;
        end else begin
            wr.stb <= 1'b0;
            if (!enable || stopSeen) begin
                state  <= ST_IDLE;
                sdaLow <= 1'b0;
            end else if (startSeen) begin
                state  <= ST_ADDR;
                bitCnt <= 4'h0;
                sdaLow <= 1'b0;
            end else if (sclRise) begin
                if (state == ST_ADDR || state == ST_REG || state == ST_WR) begin
                    shift  <= {shift[6:0], sdaIn};
                    bitCnt <= bitCnt + 4'h1;
                end else if (state == ST_RACK) begin
                    rw <= !sdaIn;  // Controller ack asks for another byte.
                end
            end else if (sclFall) begin
                case (state)
                    ST_ADDR: begin
                        if (byteDone) begin
                            sdaLow <= addrHit;
                            rw     <= shift[0];
                            state  <= addrHit ? ST_AACK : ST_IDLE;
                        end
                    end
                    ST_REG: begin
                        if (byteDone) begin
                            rdAddr <= shift;
                            sdaLow <= 1'b1;
                            state  <= ST_DACK;
                        end
                    end
                    ST_WR: begin
                        if (byteDone) begin
                            wr     <= '{stb: 1'b1, addr: rdAddr, data: shift};
                            rdAddr <= rdAddr + 8'h01;
                            sdaLow <= 1'b1;
                            state  <= ST_DACK;
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        if (rw) begin
                            shift  <= rdData;
                            sdaLow <= !rdData[7];
                            bitCnt <= 4'h1;
                            state  <= ST_RD;
                        end else begin
                            sdaLow <= 1'b0;
                            bitCnt <= 4'h0;
                            state  <= (state == ST_AACK) ? ST_REG : ST_IDLE;
                        end
                    end
                    ST_DACK: begin
                        sdaLow <= 1'b0;
                        bitCnt <= 4'h0;
                        state  <= ST_WR;
                    end
                    ST_RD: begin
                        if (byteDone) begin
                            sdaLow <= 1'b0;
                            rdAddr <= rdAddr + 8'h01;
                            state  <= ST_RACK;
                        end else begin
                            shift  <= {shift[6:0], 1'b0};
                            sdaLow <= !shift[6];
                            bitCnt <= bitCnt + 4'h1;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_start_addr: assert property (@(posedge clk_sys) disable iff (rst)
        enable && startSeen && !stopSeen |=> state == ST_ADDR && !sdaLow)
        else $error("START did not open address phase");
    chk_addr_nack: assert property (@(posedge clk_sys) disable iff (rst)
        enable && sclFall && state == ST_ADDR && byteDone && !addrHit
        |=> !sdaLow && state == ST_IDLE)
        else $error("foreign address was acknowledged");
    chk_write_ack: assert property (@(posedge clk_sys) disable iff (rst)
        wr.stb |-> sdaLow && state == ST_DACK)
        else $error("written byte not acknowledged");
    chk_stop_idle: assert property (@(posedge clk_sys) disable iff (rst)
        stopSeen |=> state == ST_IDLE && !sdaLow)
        else $error("STOP did not close transaction");

endmodule

// File: rtl/scfg_pkg.sv
// Behaviour
// - Answer on one target address, 0x18 or 0x19, picked by address strap.
// - Address strap also picks 1.8 V or 3.3 V control reference.
// - Strap pin sampled only at configuration, then drives sensor clock in synchronous and external modes.
// - Mode strap decodes to synchronous, external, internal or parallel-video mode.
// - Operating mode readable and changeable over the register port.
// - Sensor clock off in internal clock mode; on in synchronous and external.
// - Sensor clock equals channel rate times M over divider times N.
// - START is SDA falling with SCL high; STOP is SDA rising.
// - Matching address is acknowledged low; mismatch leaves SDA released.
// - Each written data byte is acknowledged by the target.
// - Every transaction opens with START and closes with STOP.
// - Mode latched from strap when power-down release rises.
// - Mode field read-only unless override bit 4 is set.
package scfg_pkg;

    // Target addresses and operating mode codes.
    localparam logic [6:0] ADDR_LO    = 7'h18;
    localparam logic [6:0] ADDR_HI    = 7'h19;
    localparam logic [2:0] MODE_SYNC  = 3'h0;
    localparam logic [2:0] MODE_NSEXT = 3'h2;
    localparam logic [2:0] MODE_NSINT = 3'h3;
    localparam logic [2:0] MODE_DVP   = 3'h5;

    // Register offsets and field positions.
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_MODE   = 8'h03;
    localparam logic [7:0] REG_CLKM   = 8'h06;
    localparam logic [7:0] REG_CLKN   = 8'h07;
    localparam int         MODE_OVR   = 4;
    localparam int         DIV_LSB    = 5;

    // Reset values of the clock parameters.
    localparam logic [4:0] RST_CLKM   = 5'h01;
    localparam logic [2:0] RST_DIVSEL = 3'h2;
    localparam logic [7:0] RST_CLKN   = 8'h1b;

    // Register write from the serial target.
    typedef struct packed {
        logic       stb;
        logic [7:0] addr;
        logic [7:0] data;
    } scfg_wr_t;

    // Serial target states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_REG  = 3'b011,
        ST_DACK = 3'b100,
        ST_WR   = 3'b101,
        ST_RD   = 3'b110,
        ST_RACK = 3'b111
    } scfg_state_t;

endpackage

// File: rtl/scfg_top.sv
`timescale 1ns/10ps
module scfg_top import scfg_pkg::*; (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Power-down release and strap levels.
    input  wire logic       powerDownReleasePin,
    input  wire logic [1:0] addressStrapLevel,
    input  wire logic [2:0] modeStrapCode,
    // Serial control bus.
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // Shared strap pin, used as sensor clock output.
    output logic            sensorClkOut,
    output logic            sensorClkOe,
    // Configuration status.
    output logic            configDone,
    output logic [6:0]      targetAddr,
    output logic            ioRef33,
    output logic [2:0]      opMode,
    output logic            modeOverride
);

    logic        pdbPrev;
    logic [4:0]  clkM;
    logic [2:0]  divSel;
    logic [7:0]  clkN;
    logic [15:0] acc;
    logic [7:0]  rdAddr;
    scfg_wr_t    wr;

    ////////////////////////////////////////////////////////////////////////
    // Strap decode.

    // Straps count on the rising edge of the power-down release, or on the first edge after reset while it is high.
    // release edge.
    wire latchNow = powerDownReleasePin && !pdbPrev;

    wire modeLegal = modeStrapCode == MODE_SYNC
                  || modeStrapCode == MODE_NSEXT
                  || modeStrapCode == MODE_NSINT
                  || modeStrapCode == MODE_DVP;

    // A code other than the four legal ones falls back to synchronous, the common setup.
    wire [2:0] modeDecoded = modeLegal ? modeStrapCode : MODE_SYNC;

    // Register writes by offset.
    wire wrMode = wr.stb && wr.addr == REG_MODE;
    wire wrClkM = wr.stb && wr.addr == REG_CLKM;
    wire wrClkN = wr.stb && wr.addr == REG_CLKN;

    ////////////////////////////////////////////////////////////////////////
    // Release edge history.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pdbPrev <= 1'b0;
        end else begin
            pdbPrev <= powerDownReleasePin;
        end
    end

    // Address and reference picked once per power-up; later level moves on
    // the pin are ignored because it is then a clock output.
    // address select.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            targetAddr <= ADDR_LO;
            ioRef33    <= 1'b0;
        end else if (latchNow) begin
            targetAddr <= addressStrapLevel[0] ? ADDR_HI : ADDR_LO;
            ioRef33    <= addressStrapLevel[1];
        end
    end

    // Configuration holds until power-down drops again.
    // hold until power-down.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            configDone <= 1'b0;
        end else if (!powerDownReleasePin) begin
            configDone <= 1'b0;
        end else if (latchNow) begin
            configDone <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register: strap value at release, overridable later.
    // override gate.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            opMode       <= MODE_SYNC;
            modeOverride <= 1'b0;
        end else if (latchNow) begin
            opMode       <= modeDecoded;
            modeOverride <= 1'b0;
        end else if (wrMode) begin
            modeOverride <= wr.data[MODE_OVR];
            if (wr.data[MODE_OVR]) begin
                opMode <= wr.data[2:0];
            end
        end
    end

    // Clock parameter registers.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clkM   <= RST_CLKM;
            divSel <= RST_DIVSEL;
            clkN   <= RST_CLKN;
        end else begin
            if (wrClkM) begin
                clkM   <= wr.data[4:0];
                divSel <= wr.data[7:DIV_LSB];
            end
            if (wrClkN) begin
                clkN <= wr.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back selection.
    // mode read.
    wire [7:0] rdMode   = {3'h0, modeOverride, 1'b0, opMode};
    wire [7:0] rdStatus = {6'h00, ioRef33, configDone};
    wire [7:0] rdClkM   = {divSel, clkM};
    wire [7:0] rdData   = (rdAddr == REG_MODE)   ? rdMode
                        : (rdAddr == REG_STATUS) ? rdStatus
                        : (rdAddr == REG_CLKM)   ? rdClkM
                        : (rdAddr == REG_CLKN)   ? clkN
                        : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Sensor clock generator.

    // Only the two modes with a sensor reference may drive the pin, and
    // only once configuration has freed the pin from strap duty.
    // clock enable.
    wire clkAllowed = configDone && (opMode == MODE_SYNC || opMode == MODE_NSEXT);

    // Each system clock stands for one channel tick. The accumulator adds
    // 2M per tick and wraps at divider times N, toggling the output, so
    // the period is divider times N over M ticks. A fractional ratio gives
    // edge jitter of one tick, the price of a small divider.
    // rate ratio.
    wire [15:0] clkLimit = {8'h00, clkN} << divSel;
    wire [15:0] clkStep  = {10'h000, clkM, 1'b0};
    wire [15:0] accSum   = acc + clkStep;
    wire        clkWrap  = accSum >= clkLimit;
    wire        clkRun   = clkAllowed && clkLimit != 16'h0000;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc          <= 16'h0000;
            sensorClkOut <= 1'b0;
        end else if (!clkRun) begin
            acc          <= 16'h0000;
            sensorClkOut <= 1'b0;
        end else if (clkWrap) begin
            acc          <= accSum - clkLimit;
            sensorClkOut <= !sensorClkOut;
        end else begin
            acc <= accSum;
        end
    end

    // Pin turnaround: drive only after configuration is complete.
    // pin handover.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sensorClkOe <= 1'b0;
        end else begin
            sensorClkOe <= clkAllowed;
        end
    end

    // SDA is open drain; the data level is always low when enabled.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial target; it never stretches SCL, so the controller never has
    // to wait on it.
    scfg_i2c_target u_target (
        .clk_sys (clk_sys),
        .rst     (rst),
        .enable  (configDone),
        .ownAddr (targetAddr),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .sdaLow  (sdaOe),
        .rdData  (rdData),
        .rdAddr  (rdAddr),
        .wr      (wr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_addr_pick: assert property (
        latchNow |=> configDone
            && targetAddr == ($past(addressStrapLevel[0]) ? ADDR_HI : ADDR_LO))
        else $error("target address does not follow strap");

    chk_ioref_pick: assert property (
        latchNow |=> ioRef33 == $past(addressStrapLevel[1]))
        else $error("reference level does not follow strap");

    chk_pin_handover: assert property (
        !configDone |=> !sensorClkOe)
        else $error("strap pin driven before configuration");

    chk_mode_decode: assert property (
        latchNow |=> opMode == $past(modeDecoded) && !modeOverride
            && (opMode == MODE_SYNC || opMode == MODE_NSEXT
                || opMode == MODE_NSINT || opMode == MODE_DVP))
        else $error("strap mode decode wrong");

    chk_mode_read: assert property (
        rdAddr == REG_MODE |-> rdData[2:0] == opMode
            && rdData[MODE_OVR] == modeOverride)
        else $error("mode read-back wrong");

    chk_int_noclk: assert property (
        (opMode == MODE_NSINT) [*2] |-> !sensorClkOe && !sensorClkOut)
        else $error("sensor clock on in internal mode");

    chk_sync_clk: assert property (
        (configDone && opMode == MODE_SYNC) [*2] |-> sensorClkOe)
        else $error("sensor clock off in synchronous mode");

    chk_clk_hold: assert property (
        clkRun && !clkWrap ##1 clkRun |-> $stable(sensorClkOut))
        else $error("sensor clock toggled early");

    chk_mode_locked: assert property (
        !latchNow && !(wrMode && wr.data[MODE_OVR]) |=> $stable(opMode))
        else $error("mode changed without override");

    chk_strap_hold: assert property (
        configDone && !latchNow |=> $stable(targetAddr) && $stable(ioRef33))
        else $error("strap configuration moved");

endmodule
